// >>> rtl/ids_fifo.sv
`timescale 1ns/100ps
module ids_fifo
    import ids_pkg::*;
#(
    parameter int WIDTH = FIFO_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output wire logic             in_ready,
    // Drain side
    output wire logic             out_valid,
    output wire logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;

    wire logic do_wr;
    wire logic do_rd;

    assign in_ready   = (count_reg != (AW+1)'(DEPTH));
    assign out_valid  = (count_reg != '0);
    assign out_data   = mem[rd_ptr_reg];
    assign do_wr      = in_valid && in_ready;
    assign do_rd      = out_valid && out_ready;
    assign count_next = count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);

    always_ff @(posedge clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Flush only follows an ordinary setting change; data in flight is dropped on purpose.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + AW'(do_wr);
            rd_ptr_reg <= rd_ptr_reg + AW'(do_rd);
            count_reg  <= count_next;
        end
    end

endmodule

// >>> rtl/ids_pkg.sv
package ids_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int CT_W       = 32;
    localparam int ALT_W      = 8;
    localparam int DATA_W     = 32;
    localparam int MPS_W      = 11;
    localparam int DLY_W      = 16;
    localparam int BURST_W    = 4;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_W     = CT_W + DATA_W;

    // ==========================================================
    // Reset values and limits
    // ==========================================================
    localparam logic [ALT_W-1:0]   RST_ALT   = 8'h00;
    localparam logic [MPS_W-1:0]   DEF_MPS   = 11'h400;
    localparam logic [DLY_W-1:0]   DEF_DLY   = 16'h0000;
    localparam logic [BURST_W-1:0] MAX_BURST = 4'h4;
    localparam logic [BURST_W-1:0] BURST_ONE = 4'h1;

    // ==========================================================
    // Request kinds and switch states
    // ==========================================================
    typedef enum logic [1:0] {
        REQ_SET_DS,
        REQ_SET_IF,
        REQ_SET_ATTR
    } ids_req_t;

    typedef enum logic {
        ST_IDLE,
        ST_PENDING
    } ids_state_t;

endpackage

// >>> rtl/ids_switch.sv
// Operation
// - Dynamic switch requests are honoured only while the interface advertises switching.
// - A DS request records a switch time and the alternate setting to follow.
// - One switch time governs every endpoint of the interface.
// - The IN format takes the new setting one cycle after channel time reaches the switch time.
// - The IN side keeps its buffered data when a DS request arrives.
// - Over-the-air IN traffic keeps the current setting until the commit step.
// - OUT data presented after the switch time is tagged with the new setting.
// - OUT data stays buffered; pre-switch data keeps the old setting.
// - After commit, all over-the-air traffic follows the new setting.
// - Set Interface without matching DS acts as an ordinary setting change.
// - A long pending switch keeps its rules and flags buffer trouble.
// - Descriptor reports default packet size; actual size and delay set separately.
// - Bursts of one up to the maximum burst size are accepted.
`timescale 1ns/100ps
module ids_switch
    import ids_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Interface capability and channel time
    input  wire logic              dyn_en,
    input  wire logic [CT_W-1:0]   ch_time,
    // Control requests
    input  wire logic              req_valid,
    input  wire ids_req_t          req_kind,
    input  wire logic [ALT_W-1:0]  req_alt,
    input  wire logic [CT_W-1:0]   req_time,
    input  wire logic [MPS_W-1:0]  req_pkt_size,
    input  wire logic [DLY_W-1:0]  req_delay,
    output wire logic              req_done,
    output wire logic              req_stall,
    // Switch status and over-the-air settings
    output wire logic              switch_pending,
    output wire logic [ALT_W-1:0]  ota_alt,
    output wire logic [ALT_W-1:0]  in_fmt_alt,
    output wire logic [MPS_W-1:0]  desc_mps,
    output wire logic [MPS_W-1:0]  act_mps,
    output wire logic [DLY_W-1:0]  act_delay,
    output wire logic              err_pending,
    // IN buffer status
    input  wire logic              in_buf_ovf,
    // OUT data from the air
    input  wire logic              out_rx_valid,
    input  wire logic [DATA_W-1:0] out_rx_data,
    input  wire logic [CT_W-1:0]   out_rx_ptime,
    output wire logic              out_rx_ready,
    // OUT data to the function
    output wire logic              out_valid,
    output wire logic [DATA_W-1:0] out_data,
    output wire logic [ALT_W-1:0]  out_alt,
    input  wire logic              out_ready,
    // Burst accounting
    input  wire logic              burst_start,
    input  wire logic              burst_pkt,
    output wire logic              burst_err
);

    // ==========================================================
    // State
    // ==========================================================
    ids_state_t        state_reg;
    logic [ALT_W-1:0]  cur_alt_reg;
    logic [ALT_W-1:0]  old_alt_reg;
    logic [ALT_W-1:0]  new_alt_reg;
    logic [CT_W-1:0]   sw_time_reg;
    logic              rec_valid_reg;
    logic              req_done_reg;
    logic              req_stall_reg;
    logic [ALT_W-1:0]  in_fmt_reg;
    logic [MPS_W-1:0]  desc_mps_reg;
    logic [MPS_W-1:0]  act_mps_reg;
    logic [DLY_W-1:0]  act_delay_reg;
    logic              err_reg;
    logic              rx_ready_reg;
    logic              out_valid_reg;
    logic [DATA_W-1:0] out_data_reg;
    logic [ALT_W-1:0]  out_alt_reg;
    logic [BURST_W-1:0] burst_cnt_reg;
    logic [BURST_W-1:0] burst_cnt_next;
    logic              burst_err_reg;

    // ==========================================================
    // Request decode
    // ==========================================================
    wire logic is_ds;
    wire logic is_set;
    wire logic ds_ok;
    wire logic ds_bad;
    wire logic set_dyn;
    wire logic set_ord;
    wire logic set_attr;

    assign is_ds    = req_valid && (req_kind == REQ_SET_DS);
    assign is_set   = req_valid && (req_kind == REQ_SET_IF);
    assign ds_ok    = is_ds && dyn_en;
    assign ds_bad   = is_ds && !dyn_en;
    assign set_dyn  = is_set && (state_reg == ST_PENDING)
                      && (req_alt == new_alt_reg);
    assign set_ord  = is_set && !set_dyn;
    assign set_attr = req_valid && (req_kind == REQ_SET_ATTR);

    // ==========================================================
    // Presentation time compares
    // ==========================================================
    wire logic           ch_after;
    wire logic           head_after;
    wire logic           fifo_out_valid;
    wire logic [FIFO_W-1:0] fifo_out_data;
    wire logic           fifo_in_ready;
    wire logic           fifo_pop;
    wire logic [ALT_W-1:0] ch_alt;
    wire logic [ALT_W-1:0] head_alt;

    ids_time_cmp u_cmp_ch
    (
        .t_now       (ch_time),
        .t_switch    (sw_time_reg),
        .at_or_after (ch_after)
    );

    ids_time_cmp u_cmp_head
    (
        .t_now       (fifo_out_data[FIFO_W-1 -: CT_W]),
        .t_switch    (sw_time_reg),
        .at_or_after (head_after)
    );

    // The record of the last switch outlives the commit so that pre-switch data
    // still queued after commit is interpreted under the old setting.
    assign ch_alt   = (rec_valid_reg && ch_after) ? new_alt_reg : old_alt_reg;
    assign head_alt = (rec_valid_reg && head_after) ? new_alt_reg : old_alt_reg;

    // ==========================================================
    // OUT buffer
    // ==========================================================
    localparam int FILL_W = $clog2(FIFO_DEPTH) + 1;

    wire logic [FILL_W-1:0] fill_next;
    wire logic              rx_accept;
    logic      [FILL_W-1:0] fill_reg;

    ids_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_out_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .flush     (set_ord),
        .in_valid  (rx_accept),
        .in_data   ({out_rx_ptime, out_rx_data}),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (fifo_pop)
    );

    assign fifo_pop = fifo_out_valid && (!out_valid_reg || out_ready) && !set_ord;

    // A local copy of the fill level lets ready come straight from a flop and
    // still drop in the very cycle in which the buffer becomes full.
    assign rx_accept = out_rx_valid && rx_ready_reg;
    assign fill_next = set_ord ? '0
                     : fill_reg + FILL_W'(rx_accept) - FILL_W'(fifo_pop);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fill_reg <= '0;
        end
        else
        begin
            fill_reg <= fill_next;
        end
    end

    // ==========================================================
    // Switch record
    // ==========================================================
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg     <= ST_IDLE;
            cur_alt_reg   <= RST_ALT;
            old_alt_reg   <= RST_ALT;
            new_alt_reg   <= RST_ALT;
            sw_time_reg   <= '0;
            rec_valid_reg <= 1'b0;
        end
        else if (ds_ok)
        begin
            state_reg     <= ST_PENDING;
            old_alt_reg   <= cur_alt_reg;
            new_alt_reg   <= req_alt;
            sw_time_reg   <= req_time;
            rec_valid_reg <= 1'b1;
        end
        else if (set_dyn)
        begin
            state_reg     <= ST_IDLE;
            cur_alt_reg   <= req_alt;
        end
        else if (set_ord)
        begin
            state_reg     <= ST_IDLE;
            cur_alt_reg   <= req_alt;
            old_alt_reg   <= req_alt;
            new_alt_reg   <= req_alt;
            rec_valid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Request answers and endpoint attributes
    // ==========================================================
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_done_reg  <= 1'b0;
            req_stall_reg <= 1'b0;
            desc_mps_reg  <= DEF_MPS;
            act_mps_reg   <= DEF_MPS;
            act_delay_reg <= DEF_DLY;
        end
        else
        begin
            req_done_reg  <= req_valid && !ds_bad;
            req_stall_reg <= ds_bad;
            desc_mps_reg  <= DEF_MPS;
            if (set_attr)
            begin
                act_mps_reg   <= req_pkt_size;
                act_delay_reg <= req_delay;
            end
        end
    end

    // ==========================================================
    // Formats and buffer trouble
    // ==========================================================
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_fmt_reg   <= RST_ALT;
            err_reg      <= 1'b0;
            rx_ready_reg <= 1'b0;
        end
        else
        begin
            in_fmt_reg   <= ch_alt;
            // Vendor handling may act on this; the switch itself carries on.
            err_reg      <= (state_reg == ST_PENDING)
                            && (in_buf_ovf || !fifo_out_valid);
            rx_ready_reg <= (fill_next != FILL_W'(FIFO_DEPTH));
        end
    end

    // ==========================================================
    // OUT output stage
    // ==========================================================
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
            out_alt_reg   <= RST_ALT;
        end
        else if (set_ord)
        begin
            out_valid_reg <= 1'b0;
        end
        else if (fifo_pop)
        begin
            out_valid_reg <= 1'b1;
            out_data_reg  <= fifo_out_data[DATA_W-1:0];
            out_alt_reg   <= head_alt;
        end
        else if (out_ready)
        begin
            out_valid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Burst accounting
    // ==========================================================
    // The count stops one past the limit, so a very long burst cannot wrap
    // back into the legal range and hide its later packets.
    assign burst_cnt_next = burst_start ? BURST_ONE
                          : (burst_cnt_reg > MAX_BURST) ? burst_cnt_reg
                          : burst_cnt_reg + BURST_W'(burst_pkt);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            burst_cnt_reg <= '0;
            burst_err_reg <= 1'b0;
        end
        else
        begin
            burst_cnt_reg <= (burst_start || burst_pkt) ? burst_cnt_next : burst_cnt_reg;
            burst_err_reg <= burst_pkt && !burst_start
                             && (burst_cnt_reg >= MAX_BURST);
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign req_done       = req_done_reg;
    assign req_stall      = req_stall_reg;
    assign switch_pending = (state_reg == ST_PENDING);
    assign ota_alt        = cur_alt_reg;
    assign in_fmt_alt     = in_fmt_reg;
    assign desc_mps       = desc_mps_reg;
    assign act_mps        = act_mps_reg;
    assign act_delay      = act_delay_reg;
    assign err_pending    = err_reg;
    assign out_rx_ready   = rx_ready_reg;
    assign out_valid      = out_valid_reg;
    assign out_data       = out_data_reg;
    assign out_alt        = out_alt_reg;
    assign burst_err      = burst_err_reg;

    // ==========================================================
    // Assertions
    // ==========================================================
    sequence s_ds_taken;
        ds_ok;
    endsequence

    sequence s_commit;
        set_dyn ##1 (ota_alt == new_alt_reg);
    endsequence

    chk_ds_gate: assert property (@(posedge clk) disable iff (!rst_b)
        ds_bad |=> req_stall && (state_reg == $past(state_reg)))
        else $error("DS request accepted without dynamic capability");

    chk_ds_record: assert property (@(posedge clk) disable iff (!rst_b)
        s_ds_taken |=> switch_pending && (new_alt_reg == $past(req_alt)))
        else $error("DS request did not record the pending setting");

    chk_one_time: assert property (@(posedge clk) disable iff (!rst_b)
        s_ds_taken |=> (sw_time_reg == $past(req_time)))
        else $error("Switch time not captured for the interface");

    chk_in_format: assert property (@(posedge clk) disable iff (!rst_b)
        (rec_valid_reg && ch_after && !req_valid) |=> (in_fmt_alt == new_alt_reg))
        else $error("IN format not switched at switch time");

    chk_keep_buffer: assert property (@(posedge clk) disable iff (!rst_b)
        (s_ds_taken && fifo_out_valid) |=> (fifo_out_valid || $past(fifo_pop)))
        else $error("Buffer flushed on a DS request");

    chk_rx_room: assert property (@(posedge clk) disable iff (!rst_b)
        rx_ready_reg |-> fifo_in_ready)
        else $error("Ready shown while the OUT buffer is full");

    chk_ota_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (switch_pending && !is_set) |=> $stable(ota_alt))
        else $error("Over-the-air setting changed before commit");

    chk_out_new: assert property (@(posedge clk) disable iff (!rst_b)
        (fifo_pop && rec_valid_reg && head_after) |=> (out_alt == $past(new_alt_reg)))
        else $error("Post-switch OUT data not tagged with new setting");

    chk_out_old: assert property (@(posedge clk) disable iff (!rst_b)
        (fifo_pop && !head_after) |=> (out_alt == $past(old_alt_reg)))
        else $error("Pre-switch OUT data not tagged with old setting");

    chk_commit: assert property (@(posedge clk) disable iff (!rst_b)
        set_dyn |-> s_commit)
        else $error("Commit did not move the over-the-air setting");

    chk_ordinary: assert property (@(posedge clk) disable iff (!rst_b)
        set_ord |=> !switch_pending && !rec_valid_reg && (ota_alt == $past(req_alt)))
        else $error("Ordinary setting change mishandled");

    chk_pend_err: assert property (@(posedge clk) disable iff (!rst_b)
        (switch_pending && in_buf_ovf && !req_valid) |=> err_pending)
        else $error("Overflow during pending switch not flagged");

    chk_desc_mps: assert property (@(posedge clk) disable iff (!rst_b)
        set_attr |=> (desc_mps == DEF_MPS) && (act_mps == $past(req_pkt_size)))
        else $error("Descriptor or actual packet size wrong");

    chk_burst_max: assert property (@(posedge clk) disable iff (!rst_b)
        (burst_pkt && !burst_start && (burst_cnt_reg < MAX_BURST)) |=> !burst_err)
        else $error("Burst within limit flagged as error");

endmodule

// >>> rtl/ids_time_cmp.sv
`timescale 1ns/100ps
module ids_time_cmp
    import ids_pkg::*;
(
    // Times to compare
    input  wire logic [CT_W-1:0] t_now,
    input  wire logic [CT_W-1:0] t_switch,
    // Result
    output wire logic            at_or_after
);

    // A signed difference keeps the compare correct across wrap of channel time.
    wire logic [CT_W-1:0] t_diff;

    assign t_diff      = t_now - t_switch;
    assign at_or_after = ~t_diff[CT_W-1];

endmodule

// >>> testbench/ids_host_model.sv
`timescale 1ns/100ps
module ids_host_model
    import ids_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_b,
    // Control from the bench
    input  wire logic            en,
    input  wire logic [CT_W-1:0] ptime_base,
    output logic      [31:0]     sent,
    // OUT stream toward the device
    output logic                 out_rx_valid,
    output logic [DATA_W-1:0]    out_rx_data,
    output logic [CT_W-1:0]      out_rx_ptime,
    input  wire logic            out_rx_ready
);
    // ==========================================================
    // Word source
    // ==========================================================
    // An offer is held until taken; once released the lines toggle so
    // that stale values can never pass for fresh ones.
    wire logic        accept = out_rx_valid && out_rx_ready;
    wire logic [31:0] nxt    = sent + {31'h0, accept};

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sent         <= 32'h0;
            out_rx_valid <= 1'b0;
            out_rx_data  <= 32'hFFFFFFFF;
            out_rx_ptime <= 32'hFFFFFFFF;
        end
        else
        begin
            sent <= nxt;
            if (!out_rx_valid || accept)
            begin
                out_rx_valid <= en;
                out_rx_data  <= en ? nxt : ~out_rx_data;
                out_rx_ptime <= en ? ptime_base + nxt : ~out_rx_ptime;
            end
        end
    end
endmodule

// >>> testbench/ids_switch_tb.sv
`timescale 1ns/100ps
module ids_switch_tb
    import ids_pkg::*;
;
    // ==========================================================
    // Signals
    // ==========================================================
    logic              clk, rst_b, dyn_en, req_valid, in_buf_ovf;
    logic              out_ready, burst_start, burst_pkt, en;
    ids_req_t          req_kind;
    logic [ALT_W-1:0]  req_alt;
    logic [CT_W-1:0]   ch_time, req_time, pbase, t_sw;
    logic [MPS_W-1:0]  req_pkt_size;
    logic [DLY_W-1:0]  req_delay;
    wire logic         req_done, req_stall, switch_pending, err_pending;
    wire logic         out_rx_valid, out_rx_ready, out_valid, burst_err;
    wire logic [ALT_W-1:0]  ota_alt, in_fmt_alt, out_alt;
    wire logic [MPS_W-1:0]  desc_mps, act_mps;
    wire logic [DLY_W-1:0]  act_delay;
    wire logic [DATA_W-1:0] out_rx_data, out_data;
    wire logic [CT_W-1:0]   out_rx_ptime;
    wire logic [31:0]       sent;
    int                mismatches, cmp_count, k;
    int                cycles = 0;

    ids_switch dut (.clk(clk), .rst_b(rst_b), .dyn_en(dyn_en), .ch_time(ch_time),
        .req_valid(req_valid), .req_kind(req_kind), .req_alt(req_alt), .req_time(req_time),
        .req_pkt_size(req_pkt_size), .req_delay(req_delay), .req_done(req_done),
        .req_stall(req_stall), .switch_pending(switch_pending), .ota_alt(ota_alt),
        .in_fmt_alt(in_fmt_alt), .desc_mps(desc_mps), .act_mps(act_mps),
        .act_delay(act_delay), .err_pending(err_pending), .in_buf_ovf(in_buf_ovf),
        .out_rx_valid(out_rx_valid), .out_rx_data(out_rx_data),
        .out_rx_ptime(out_rx_ptime), .out_rx_ready(out_rx_ready), .out_valid(out_valid),
        .out_data(out_data), .out_alt(out_alt), .out_ready(out_ready),
        .burst_start(burst_start), .burst_pkt(burst_pkt), .burst_err(burst_err));

    ids_host_model host (.clk(clk), .rst_b(rst_b), .en(en), .ptime_base(pbase),
        .sent(sent), .out_rx_valid(out_rx_valid), .out_rx_data(out_rx_data),
        .out_rx_ptime(out_rx_ptime), .out_rx_ready(out_rx_ready));

    // ==========================================================
    // Clock, channel time and timeout
    // ==========================================================
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        ch_time <= rst_b ? ch_time + 32'h1 : 32'h0;
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic wrap_up();
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic req(input ids_req_t kd, input logic [7:0] a, input logic [31:0] t,
                       input logic ok);
        @(posedge clk);
        req_valid <= 1'b1;
        req_kind  <= kd;
        req_alt   <= a;
        req_time  <= t;
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        chk("req_done", ok, req_done);
        chk("req_stall", !ok, req_stall);
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_refused();
        @(posedge clk);
        dyn_en <= 1'b0;
        req(REQ_SET_DS, 8'h03, ch_time + 32'h10, 1'b0);
        chk("pending", 1'b0, switch_pending);
        @(posedge clk);
        dyn_en <= 1'b1;
    endtask

    task automatic t_ds();
        t_sw = ch_time + 32'h40;
        req(REQ_SET_DS, 8'h02, t_sw, 1'b1);
        chk("pending", 1'b1, switch_pending);
        while (ch_time !== t_sw)
        begin
            @(posedge clk);
            #1;
        end
        chk("in_fmt_alt", 8'h00, in_fmt_alt);
        @(posedge clk);
        #1;
        chk("in_fmt_alt", 8'h02, in_fmt_alt);
        chk("ota_alt", 8'h00, ota_alt);
    endtask

    // Fill while the function side stalls, then drain and check order and format.
    task automatic t_stream();
        @(posedge clk);
        out_ready <= 1'b0;
        pbase     <= t_sw - 32'h4;
        en        <= 1'b1;
        repeat (60) @(posedge clk);
        en <= 1'b0;
        #1;
        chk("accepted", FIFO_DEPTH + 1, sent);
        chk("out_rx_ready", 1'b0, out_rx_ready);
        @(posedge clk);
        out_ready <= 1'b1;
        k = 0;
        repeat (80)
        begin
            @(negedge clk);
            if (out_valid === 1'b1)
            begin
                chk("out_data", k, out_data);
                chk("out_alt", k >= 4 ? 2 : 0, out_alt);
                k++;
            end
        end
        chk("drained", sent, k);
        chk("err_pending", 1'b1, err_pending);
    endtask

    task automatic t_commit();
        @(posedge clk);
        in_buf_ovf <= 1'b1;
        req(REQ_SET_IF, 8'h02, 32'h0, 1'b1);
        chk("ota_alt", 8'h02, ota_alt);
        chk("pending", 1'b0, switch_pending);
        @(posedge clk);
        in_buf_ovf <= 1'b0;
        #1;
        chk("err_pending", 1'b0, err_pending);
    endtask

    task automatic t_ordinary();
        req(REQ_SET_IF, 8'h05, 32'h0, 1'b1);
        chk("ota_alt", 8'h05, ota_alt);
        req(REQ_SET_DS, 8'h06, ch_time + 32'h100, 1'b1);
        req(REQ_SET_IF, 8'h07, 32'h0, 1'b1);
        chk("ota_alt", 8'h07, ota_alt);
    endtask

    task automatic t_attr();
        @(posedge clk);
        req_pkt_size <= 11'h200;
        req_delay    <= 16'h0123;
        req(REQ_SET_ATTR, 8'h00, 32'h0, 1'b1);
        chk("act_mps", 11'h200, act_mps);
        chk("act_delay", 16'h0123, act_delay);
        chk("desc_mps", 11'h400, desc_mps);
    endtask

    task automatic t_burst();
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            burst_pkt   <= 1'b1;
            burst_start <= (i == 0);
            #1;
            if (i == 4)
                chk("burst_err", 1'b0, burst_err);
        end
        @(posedge clk);
        burst_pkt   <= 1'b0;
        burst_start <= 1'b0;
        #1;
        chk("burst_err", 1'b1, burst_err);
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        {rst_b, req_valid, in_buf_ovf, burst_start, burst_pkt, en} = 6'h00;
        {dyn_en, out_ready} = 2'h3;
        req_kind     = REQ_SET_DS;
        {req_alt, req_time, pbase} = 72'h0;
        {req_pkt_size, req_delay} = 27'h0;
        {mismatches, cmp_count} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("ota_alt", RST_ALT, ota_alt);
        chk("desc_mps", DEF_MPS, desc_mps);
        chk("act_mps", DEF_MPS, act_mps);
        t_refused();
        t_ds();
        t_stream();
        t_commit();
        t_ordinary();
        t_attr();
        t_burst();
        wrap_up();
    end
endmodule
